/* File: logic/tmr_params.svh */
// register offsets, field positions, reset values and timing counts for the timer
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ============================================================
// register offsets (byte index on the register port)
`define TMR_OFF_CTRL_TWO    5'h11
`define TMR_OFF_CTRL_ONE    5'h12
`define TMR_OFF_STATUS      5'h13
`define TMR_OFF_CAP1_HI     5'h14
`define TMR_OFF_CAP1_LO     5'h15
`define TMR_OFF_CMP1_HI     5'h16
`define TMR_OFF_CMP1_LO     5'h17
`define TMR_OFF_CNT_HI      5'h18
`define TMR_OFF_CNT_LO      5'h19
`define TMR_OFF_ALT_HI      5'h1A
`define TMR_OFF_ALT_LO      5'h1B
`define TMR_OFF_CAP2_HI     5'h1C
`define TMR_OFF_CAP2_LO     5'h1D
`define TMR_OFF_CMP2_HI     5'h1E
`define TMR_OFF_CMP2_LO     5'h1F

// ============================================================
// control one fields
`define TMR_C1_CAP_IE       7
`define TMR_C1_CMP_IE       6
`define TMR_C1_OVF_IE       5
`define TMR_C1_FORCE2       4
`define TMR_C1_FORCE1       3
`define TMR_C1_LVL2         2
`define TMR_C1_CAP1_EDGE    1
`define TMR_C1_LVL1         0

// control two fields
`define TMR_C2_PIN1_EN      7
`define TMR_C2_PIN2_EN      6
`define TMR_C2_ONE_PULSE    5
`define TMR_C2_PWM          4
`define TMR_C2_CLK_HI       3
`define TMR_C2_CLK_LO       2
`define TMR_C2_CAP2_EDGE    1
`define TMR_C2_EXT_EDGE     0

// status fields
`define TMR_SR_CAP1         7
`define TMR_SR_CMP1         6
`define TMR_SR_OVF          5
`define TMR_SR_CAP2         4
`define TMR_SR_CMP2         3

// ============================================================
// reset values
`define TMR_RST_CTRL        8'h00
`define TMR_RST_CMP_HI      8'h80
`define TMR_RST_CMP_LO      8'h00
`define TMR_RST_COUNT       16'hFFFC
`define TMR_PWM_RELOAD      16'hFFFC
`define TMR_COUNT_MAX       16'hFFFF

// ============================================================
// prescaler divides
`define TMR_DIV_BY2         3'h1
`define TMR_DIV_BY4         3'h3
`define TMR_DIV_BY8         3'h7

`endif

/* File: logic/tmr_pkg.sv */
// types shared by the timer files
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_CLK_DIV4 = 2'h0,
        TMR_CLK_DIV2 = 2'h1,
        TMR_CLK_DIV8 = 2'h2,
        TMR_CLK_EXT  = 2'h3
    } tmr_clk_sel_t;

    typedef enum logic [2:0] {
        TMR_OP_IDLE  = 3'b001,
        TMR_OP_ARMED = 3'b010,
        TMR_OP_PULSE = 3'b100
    } tmr_pulse_st_t;
endpackage

/* File: logic/tmr_tick_gen.sv */
// timer tick source: cpu prescaler or edge-selected external clock
`include "tmr_params.svh"

module tmr_tick_gen #(
    parameter bit EXT_PIN_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // selection
    input  wire tmr_pkg::tmr_clk_sel_t clk_sel,
    input  wire logic               ext_edge_rise,
    input  wire logic               ext_clock_pin,
    // tick
    output logic                    tick_ff
);
    logic [2:0] pre_ff;
    logic       ext_prev_ff;
    logic       ext_edge;
    logic [2:0] div_mask;

    always_comb begin
        unique case (clk_sel)
            tmr_pkg::TMR_CLK_DIV4: div_mask = `TMR_DIV_BY4;
            tmr_pkg::TMR_CLK_DIV2: div_mask = `TMR_DIV_BY2;
            tmr_pkg::TMR_CLK_DIV8: div_mask = `TMR_DIV_BY8;
            tmr_pkg::TMR_CLK_EXT:  div_mask = `TMR_DIV_BY8;
        endcase
    end

    assign ext_edge = ext_edge_rise ? (ext_clock_pin & ~ext_prev_ff)
                                    : (~ext_clock_pin & ext_prev_ff);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pre_ff      <= 3'h0;
            ext_prev_ff <= 1'b0;
        end else if (clk_en) begin
            pre_ff      <= pre_ff + 3'h1;
            ext_prev_ff <= ext_clock_pin;
        end
    end

    // tick is registered so the counter sees a clean one-cycle strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_ff <= 1'b0;
        end else if (clk_en) begin
            if (clk_sel == tmr_pkg::TMR_CLK_EXT) begin
                tick_ff <= EXT_PIN_PRESENT & ext_edge;
            end else begin
                tick_ff <= ((pre_ff & div_mask) == div_mask);
            end
        end
    end
endmodule

/* File: logic/tmr_core.sv */
// sixteen-bit timer with two captures, two compares, one-pulse and pwm modes
// How it works
// - capture enable lets either capture flag raise the timer interrupt.
// - compare enable lets either compare flag raise the timer interrupt.
// - overflow enable lets the overflow flag raise the timer interrupt.
// - force bit two copies level two onto pin two when enabled.
// - force bit one copies level one onto pin one when enabled, outside pwm and one-pulse modes.
// - compare two match drives level two; pin one in pwm, no pin in one-pulse.
// - capture one edge select: zero falling, one rising.
// - compare one match drives level one onto pin one when enabled.
// - pin one enable only routes output; compare one runs regardless.
// - pin two enable only routes output; compare two runs regardless.
// - one-pulse mode: capture one edge starts a pulse timed by compare one.
// - pwm: pulse length from compare one, period from compare two.
// - clock select picks divide by 4, 2, 8 or external clock.
// - without an external pin, external selection halts the counter.
// - capture two edge select: zero falling, one rising.
// - external clock edge select: zero falling, one rising.
// - capture one flag sets on edge or pwm period; status then low byte clears. A capture one edge in one-pulse or pwm mode does not set it.
// - compare one flag sets on match; status then low byte access clears. A match in one-pulse mode does not set it.
// - overflow flag sets on wrap; counter low clears, alternate never.
// - capture two flag sets on edge and loads capture two.
// - compare two flag sets on match; status then low byte access clears.
// - low three status bits always read zero.
// - pwm compare two match reloads the counter to FFFC.
// - high byte write suspends that compare until low byte written.
// - pwm mode never sets compare flags.
// - pwm and one-pulse together behave as pwm only.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "tmr_params.svh"

module tmr_core #(
    parameter bit EXT_PIN_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // register port
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_ff,
    // pins
    input  wire logic       capture_in_pin_one,
    input  wire logic       capture_in_pin_two,
    input  wire logic       ext_clock_pin,
    output logic            compare_out_pin_one,
    output logic            compare_out_pin_two,
    output logic            pin_one_owned,
    output logic            pin_two_owned,
    // interrupt request
    output logic            timer_irq_ff
);
    // ============================================================
    // registers
    logic [7:0]  ctrl_one_ff;
    logic [7:0]  ctrl_two_ff;
    logic [15:0] count_ff;
    logic [15:0] cap1_ff;
    logic [15:0] cap2_ff;
    logic [15:0] cmp1_ff;
    logic [15:0] cmp2_ff;
    logic        cmp1_hold_ff;
    logic        cmp2_hold_ff;
    logic        cap1_flag_ff;
    logic        cmp1_flag_ff;
    logic        ovf_flag_ff;
    logic        cap2_flag_ff;
    logic        cmp2_flag_ff;
    logic        sr_armed_ff;
    logic        pin1_lvl_ff;
    logic        pin2_lvl_ff;
    logic        pin1_en_ff;
    logic        pin2_en_ff;
    logic        cap1_prev_ff;
    logic        cap2_prev_ff;
    tmr_pkg::tmr_pulse_st_t op_st_ff;
    tmr_pkg::tmr_pulse_st_t nxt_op_st;

    logic        tick;
    logic        any_acc;
    logic        pwm_on;
    logic        opm_on;
    logic        cmp1_hit;
    logic        cmp2_hit;
    logic        cap1_edge;
    logic        cap2_edge;
    logic        cnt_clear;
    logic [7:0]  status_byte;

    // ============================================================
    // helpers
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off,
                                 input logic acc);
        hit = acc && (a == off);
    endfunction

    function automatic logic edge_seen(input logic now, input logic prev,
                                       input logic rise);
        edge_seen = rise ? (now & ~prev) : (~now & prev);
    endfunction

    assign any_acc   = reg_wr | reg_rd;
    assign pwm_on    = ctrl_two_ff[`TMR_C2_PWM];
    assign opm_on    = ctrl_two_ff[`TMR_C2_ONE_PULSE] & ~pwm_on;
    // compares stay inactive while their hold is set, between a high and a low byte write
    assign cmp1_hit  = tick && !cmp1_hold_ff && (count_ff == cmp1_ff);
    assign cmp2_hit  = tick && !cmp2_hold_ff && (count_ff == cmp2_ff);
    assign cap1_edge = edge_seen(capture_in_pin_one, cap1_prev_ff,
                                 ctrl_one_ff[`TMR_C1_CAP1_EDGE]);
    assign cap2_edge = edge_seen(capture_in_pin_two, cap2_prev_ff,
                                 ctrl_two_ff[`TMR_C2_CAP2_EDGE]);
    assign cnt_clear = hit(reg_addr, `TMR_OFF_CNT_LO, reg_wr)
                     | hit(reg_addr, `TMR_OFF_ALT_LO, reg_wr);
    assign status_byte = {cap1_flag_ff, cmp1_flag_ff, ovf_flag_ff, cap2_flag_ff,
                          cmp2_flag_ff, 3'h0};

    tmr_tick_gen #(
        .EXT_PIN_PRESENT (EXT_PIN_PRESENT)
    ) u_tick (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .clk_en        (clk_en),
        .clk_sel       (tmr_pkg::tmr_clk_sel_t'(ctrl_two_ff[`TMR_C2_CLK_HI:`TMR_C2_CLK_LO])),
        .ext_edge_rise (ctrl_two_ff[`TMR_C2_EXT_EDGE]),
        .ext_clock_pin (ext_clock_pin),
        .tick_ff       (tick)
    );

    // ============================================================
    // control registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_one_ff <= `TMR_RST_CTRL;
            ctrl_two_ff <= `TMR_RST_CTRL;
        end else if (clk_en) begin
            if (hit(reg_addr, `TMR_OFF_CTRL_ONE, reg_wr)) begin
                ctrl_one_ff <= reg_wdata;
            end
            if (hit(reg_addr, `TMR_OFF_CTRL_TWO, reg_wr)) begin
                ctrl_two_ff <= reg_wdata;
            end
        end
    end

    // ============================================================
    // compare values and the high-byte hold
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmp1_ff      <= {`TMR_RST_CMP_HI, `TMR_RST_CMP_LO};
            cmp2_ff      <= {`TMR_RST_CMP_HI, `TMR_RST_CMP_LO};
            cmp1_hold_ff <= 1'b0;
            cmp2_hold_ff <= 1'b0;
        end else if (clk_en) begin
            if (hit(reg_addr, `TMR_OFF_CMP1_HI, reg_wr)) begin
                cmp1_ff[15:8] <= reg_wdata;
                cmp1_hold_ff  <= 1'b1;
            end
            if (hit(reg_addr, `TMR_OFF_CMP1_LO, reg_wr)) begin
                cmp1_ff[7:0]  <= reg_wdata;
                cmp1_hold_ff  <= 1'b0;
            end
            if (hit(reg_addr, `TMR_OFF_CMP2_HI, reg_wr)) begin
                cmp2_ff[15:8] <= reg_wdata;
                cmp2_hold_ff  <= 1'b1;
            end
            if (hit(reg_addr, `TMR_OFF_CMP2_LO, reg_wr)) begin
                cmp2_ff[7:0]  <= reg_wdata;
                cmp2_hold_ff  <= 1'b0;
            end
        end
    end

    // ============================================================
    // free-running counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_ff <= `TMR_RST_COUNT;
        end else if (clk_en) begin
            if (cnt_clear) begin
                count_ff <= `TMR_RST_COUNT;
            end else if (pwm_on && cmp2_hit) begin
                count_ff <= `TMR_PWM_RELOAD;
            end else if (tick) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    // ============================================================
    // captures; pin one is taken over by the pulse modes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cap1_prev_ff <= 1'b0;
            cap2_prev_ff <= 1'b0;
            cap1_ff      <= 16'h0000;
            cap2_ff      <= 16'h0000;
        end else if (clk_en) begin
            cap1_prev_ff <= capture_in_pin_one;
            cap2_prev_ff <= capture_in_pin_two;
            if (cap1_edge && !pwm_on && !opm_on) begin
                cap1_ff <= count_ff;
            end
            if (cap2_edge) begin
                cap2_ff <= count_ff;
            end
        end
    end

    // ============================================================
    // status flags: a status read arms the clear, the low byte access fires it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sr_armed_ff <= 1'b0;
        end else if (clk_en) begin
            if (hit(reg_addr, `TMR_OFF_STATUS, reg_rd)) begin
                sr_armed_ff <= 1'b1;
            end
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cap1_flag_ff <= 1'b0;
            cmp1_flag_ff <= 1'b0;
            ovf_flag_ff  <= 1'b0;
            cap2_flag_ff <= 1'b0;
            cmp2_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if ((cap1_edge && !pwm_on && !opm_on) || (pwm_on && cmp2_hit)) begin
                cap1_flag_ff <= 1'b1;
            end else if (sr_armed_ff && hit(reg_addr, `TMR_OFF_CAP1_LO, any_acc)) begin
                cap1_flag_ff <= 1'b0;
            end
            if (cmp1_hit && !pwm_on && !opm_on) begin
                cmp1_flag_ff <= 1'b1;
            end else if (sr_armed_ff && hit(reg_addr, `TMR_OFF_CMP1_LO, any_acc)) begin
                cmp1_flag_ff <= 1'b0;
            end
            if (tick && !cnt_clear && !(pwm_on && cmp2_hit)
                && count_ff == `TMR_COUNT_MAX) begin
                ovf_flag_ff <= 1'b1;
            end else if (sr_armed_ff && hit(reg_addr, `TMR_OFF_CNT_LO, any_acc)) begin
                ovf_flag_ff <= 1'b0;
            end
            if (cap2_edge) begin
                cap2_flag_ff <= 1'b1;
            end else if (sr_armed_ff && hit(reg_addr, `TMR_OFF_CAP2_LO, any_acc)) begin
                cap2_flag_ff <= 1'b0;
            end
            if (cmp2_hit && !pwm_on) begin
                cmp2_flag_ff <= 1'b1;
            end else if (sr_armed_ff && hit(reg_addr, `TMR_OFF_CMP2_LO, any_acc)) begin
                cmp2_flag_ff <= 1'b0;
            end
        end
    end

    // ============================================================
    // one-pulse sequencer: capture one edge starts, compare one ends
    always_comb begin
        nxt_op_st = op_st_ff;
        unique case (op_st_ff)
            tmr_pkg::TMR_OP_IDLE:  if (opm_on) nxt_op_st = tmr_pkg::TMR_OP_ARMED;
            tmr_pkg::TMR_OP_ARMED: begin
                if (!opm_on) begin
                    nxt_op_st = tmr_pkg::TMR_OP_IDLE;
                end else if (cap1_edge) begin
                    nxt_op_st = tmr_pkg::TMR_OP_PULSE;
                end
            end
            tmr_pkg::TMR_OP_PULSE: begin
                if (!opm_on) begin
                    nxt_op_st = tmr_pkg::TMR_OP_IDLE;
                end else if (cmp1_hit) begin
                    nxt_op_st = tmr_pkg::TMR_OP_ARMED;
                end
            end
            default: nxt_op_st = tmr_pkg::TMR_OP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            op_st_ff <= tmr_pkg::TMR_OP_IDLE;
        end else if (clk_en) begin
            op_st_ff <= nxt_op_st;
        end
    end

    // ============================================================
    // compare output levels; internal level runs whatever the pin enables say
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin1_lvl_ff <= 1'b0;
            pin2_lvl_ff <= 1'b0;
        end else if (clk_en) begin
            if (pwm_on) begin
                if (cmp2_hit) begin
                    pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL2];
                end else if (cmp1_hit) begin
                    pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL1];
                end
            end else if (opm_on) begin
                if (op_st_ff == tmr_pkg::TMR_OP_ARMED && cap1_edge) begin
                    pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL2];
                end else if (op_st_ff == tmr_pkg::TMR_OP_PULSE && cmp1_hit) begin
                    pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL1];
                end
            end else if (ctrl_one_ff[`TMR_C1_FORCE1]) begin
                pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL1];
            end else if (cmp1_hit) begin
                pin1_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL1];
            end
            if (ctrl_one_ff[`TMR_C1_FORCE2]) begin
                pin2_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL2];
            end else if (cmp2_hit && !pwm_on && !opm_on) begin
                pin2_lvl_ff <= ctrl_one_ff[`TMR_C1_LVL2];
            end
        end
    end

    // pin ownership only routes the level out
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin1_en_ff <= 1'b0;
            pin2_en_ff <= 1'b0;
        end else if (clk_en) begin
            pin1_en_ff <= ctrl_two_ff[`TMR_C2_PIN1_EN];
            pin2_en_ff <= ctrl_two_ff[`TMR_C2_PIN2_EN];
        end
    end

    assign compare_out_pin_one = pin1_lvl_ff;
    assign compare_out_pin_two = pin2_lvl_ff;
    assign pin_one_owned       = pin1_en_ff;
    assign pin_two_owned       = pin2_en_ff;

    // ============================================================
    // interrupt request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_irq_ff <= 1'b0;
        end else if (clk_en) begin
            timer_irq_ff <= (ctrl_one_ff[`TMR_C1_CAP_IE] & (cap1_flag_ff | cap2_flag_ff))
                          | (ctrl_one_ff[`TMR_C1_CMP_IE] & (cmp1_flag_ff | cmp2_flag_ff))
                          | (ctrl_one_ff[`TMR_C1_OVF_IE] & ovf_flag_ff);
        end
    end

    // ============================================================
    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (clk_en) begin
            reg_rdata_ff <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    `TMR_OFF_CTRL_TWO: reg_rdata_ff <= ctrl_two_ff;
                    `TMR_OFF_CTRL_ONE: reg_rdata_ff <= ctrl_one_ff;
                    `TMR_OFF_STATUS:   reg_rdata_ff <= status_byte;
                    `TMR_OFF_CAP1_HI:  reg_rdata_ff <= cap1_ff[15:8];
                    `TMR_OFF_CAP1_LO:  reg_rdata_ff <= cap1_ff[7:0];
                    `TMR_OFF_CMP1_HI:  reg_rdata_ff <= cmp1_ff[15:8];
                    `TMR_OFF_CMP1_LO:  reg_rdata_ff <= cmp1_ff[7:0];
                    `TMR_OFF_CNT_HI:   reg_rdata_ff <= count_ff[15:8];
                    `TMR_OFF_CNT_LO:   reg_rdata_ff <= count_ff[7:0];
                    `TMR_OFF_ALT_HI:   reg_rdata_ff <= count_ff[15:8];
                    `TMR_OFF_ALT_LO:   reg_rdata_ff <= count_ff[7:0];
                    `TMR_OFF_CAP2_HI:  reg_rdata_ff <= cap2_ff[15:8];
                    `TMR_OFF_CAP2_LO:  reg_rdata_ff <= cap2_ff[7:0];
                    `TMR_OFF_CMP2_HI:  reg_rdata_ff <= cmp2_ff[15:8];
                    `TMR_OFF_CMP2_LO:  reg_rdata_ff <= cmp2_ff[7:0];
                    default:           reg_rdata_ff <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* File: sim/tmr_core_props.sv */
// concurrent checks on the timer core ports
module tmr_core_props (
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    // pins and request
    input wire logic       compare_out_pin_one,
    input wire logic       compare_out_pin_two,
    input wire logic       pin_one_owned,
    input wire logic       pin_two_owned,
    input wire logic       timer_irq_ff
);
    // ====
    // shadow of the control registers, so pin rules can be judged from the bus
    logic [7:0] c1_ff;
    logic [7:0] c2_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            c1_ff <= 8'h00;
            c2_ff <= 8'h00;
        end else if (reg_wr && reg_addr == 5'h12) begin
            c1_ff <= reg_wdata;
        end else if (reg_wr && reg_addr == 5'h11) begin
            c2_ff <= reg_wdata;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_sr_read;
        reg_rd && reg_addr == 5'h13;
    endsequence
    sequence s_quiet;
        $stable(c1_ff) && $stable(c2_ff) && c2_ff[5:4] == 2'h0;
    endsequence
    property p_sr_low;
        s_sr_read |=> reg_rdata_ff[2:0] == 3'h0;
    endproperty
    property p_own1;
        $stable(c2_ff[7]) |-> pin_one_owned == c2_ff[7];
    endproperty
    property p_own2;
        $stable(c2_ff[6]) |-> pin_two_owned == c2_ff[6];
    endproperty
    property p_force1;
        s_quiet and c1_ff[3] |-> compare_out_pin_one == c1_ff[0];
    endproperty
    property p_force2;
        s_quiet and c1_ff[4] |-> compare_out_pin_two == c1_ff[2];
    endproperty
    property p_irq_off;
        c1_ff[7:5] == 3'h0 && $stable(c1_ff[7:5]) |-> !timer_irq_ff;
    endproperty
    property p_irq_ovf;
        s_sr_read ##1 (reg_rdata_ff[5] && c1_ff[5] && $stable(c1_ff)) |-> timer_irq_ff;
    endproperty
    property p_irq_cap;
        s_sr_read ##1 ((reg_rdata_ff[7] || reg_rdata_ff[4]) && c1_ff[7] && $stable(c1_ff))
            |-> timer_irq_ff;
    endproperty
    property p_irq_cmp;
        s_sr_read ##1 ((reg_rdata_ff[6] || reg_rdata_ff[3]) && c1_ff[6] && $stable(c1_ff))
            |-> timer_irq_ff;
    endproperty
    a_sr_low: assert property (p_sr_low) else $error("status low bits not zero");
    a_own1: assert property (p_own1) else $error("pin one ownership wrong");
    a_own2: assert property (p_own2) else $error("pin two ownership wrong");
    a_force1: assert property (p_force1) else $error("forced pin one wrong");
    a_force2: assert property (p_force2) else $error("forced pin two wrong");
    a_irq_off: assert property (p_irq_off) else $error("request while disabled");
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request missing");
    a_irq_cap: assert property (p_irq_cap) else $error("capture request missing");
    a_irq_cmp: assert property (p_irq_cmp) else $error("compare request missing");
endmodule

bind tmr_core tmr_core_props tmr_core_props_inst (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .compare_out_pin_one(compare_out_pin_one), .compare_out_pin_two(compare_out_pin_two),
    .pin_one_owned(pin_one_owned), .pin_two_owned(pin_two_owned),
    .timer_irq_ff(timer_irq_ff));

/* File: sim/tmr_pins_model.sv */
// pin-side model: capture input two and external clock source
module tmr_pins_model (
    // clock
    input wire logic clock,
    // pins toward the timer
    output logic     capture_in_pin_two,
    output logic     ext_clock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        capture_in_pin_two = 1'b0;
        ext_clock_pin = 1'b0;
    end
    task automatic set_cap_two(input logic lvl);
        @(posedge clock);
        capture_in_pin_two <= lvl;
    endtask
    // the external clock only moves while a burst is asked for
    task automatic ext_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            ext_clock_pin <= 1'b1;
            repeat (2) @(posedge clock);
            ext_clock_pin <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the timer core
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, sys_rst, reg_wr, reg_rd, cap_one, cap_two, ext_clk;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_ff;
    logic       pin_one, pin_two, own_one, own_two, irq;
    int         err_count, tests_run;
    logic [4:0] ra [8] = '{5'h13, 5'h12, 5'h11, 5'h16, 5'h17, 5'h1E, 5'h1F, 5'h05};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
    tmr_core tmr_core_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .capture_in_pin_one(cap_one),
        .capture_in_pin_two(cap_two), .ext_clock_pin(ext_clk),
        .compare_out_pin_one(pin_one), .compare_out_pin_two(pin_two),
        .pin_one_owned(own_one), .pin_two_owned(own_two), .timer_irq_ff(irq));
    tmr_pins_model tmr_pins_model_inst (.clock(clock), .capture_in_pin_two(cap_two),
        .ext_clock_pin(ext_clk));
    // ====
    // shared tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), reg_rdata_ff, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_reset_values;
        wr(5'h05, 8'hFF);
        for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
    endtask
    task automatic t_overflow;
        idle(20);
        wr(5'h12, 8'h20);
        idle(3);
        chk("overflow request", {7'h00, irq}, 8'h01);
        rdc(5'h13, 8'h20);
        wr(5'h11, 8'h0C);
        wr(5'h1B, 8'h00);
        rdc(5'h13, 8'h20);
        rdc(5'h19, 8'hFC);
        rdc(5'h13, 8'h00);
    endtask
    task automatic t_capture_two;
        wr(5'h12, 8'h80);
        wr(5'h11, 8'h0E);
        tmr_pins_model_inst.set_cap_two(1'b1);
        idle(4);
        chk("capture request", {7'h00, irq}, 8'h01);
        rdc(5'h13, 8'h10);
        rdc(5'h1D, 8'hFC);
        rdc(5'h13, 8'h00);
        tmr_pins_model_inst.set_cap_two(1'b0);
        idle(4);
        rdc(5'h13, 8'h00);
    endtask
    task automatic t_ext_compare;
        wr(5'h12, 8'h41);
        wr(5'h11, 8'h8D);
        wr(5'h16, 8'h00);
        wr(5'h17, 8'h01);
        wr(5'h1E, 8'h00);
        wr(5'h19, 8'h00);
        tmr_pins_model_inst.ext_pulses(6);
        idle(3);
        chk("compare request", {7'h00, irq}, 8'h01);
        chk("pin one", {7'h00, pin_one}, 8'h01);
        rdc(5'h13, 8'h60);
        wr(5'h1F, 8'h03);
        tmr_pins_model_inst.ext_pulses(2);
        idle(3);
        rdc(5'h13, 8'h68);
        wr(5'h17, 8'h01);
        rdc(5'h1F, 8'h03);
        rdc(5'h19, 8'h04);
        rdc(5'h13, 8'h00);
    endtask
    task automatic t_force;
        wr(5'h12, 8'h18);
        idle(3);
        chk("forced low", {6'h00, pin_two, pin_one}, 8'h00);
        wr(5'h12, 8'h1D);
        idle(3);
        chk("forced high", {6'h00, pin_two, pin_one}, 8'h03);
        chk("owned", {6'h00, own_two, own_one}, 8'h01);
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        cap_one = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset_values();
        t_overflow();
        t_capture_two();
        t_ext_compare();
        t_force();
        give_verdict();
    end
endmodule
